// ==== design/operand_target_map.svh ====
// constants for operand and branch-target decoding
`ifndef OPERAND_TARGET_MAP_SVH
`define OPERAND_TARGET_MAP_SVH
`define ADDR_W       16
`define PAGE_LSB_W   11
`define PAGE_HI_LSB  11
`define PAGE_HI_MSB  15
`define SEL_FLAG     2'h0
`define SEL_REGBIT   2'h1
`define FLAG_LIMIT   8'h80
`define REGBIT_GRP   8'h08
`define PC_RESET     16'h0000
`define IMM_RESET    16'h0000
`define PAGE_OP_MSB  7
`define PAGE_OP_LSB  5
`define BIT_BYTE_MSB 7
`define FLAG_BYTE_MSB 6
`define BIT_BYTE_LSB 3
`define BIT_IDX_MSB  2
`endif

// ==== design/operand_target_pkg.sv ====
// types for operand and branch-target decoding
package operand_target_pkg;
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_FULL,
		TGT_PAGE,
		TGT_REL
	} target_form_t;
	typedef enum logic [1:0] {
		IMM_NONE,
		IMM_BYTE,
		IMM_WORD
	} imm_form_t;
endpackage : operand_target_pkg

// ==== design/bit_operand_map.sv ====
// bit operand decoder: flag area or register bit
`timescale 1ns/1ns
`include "operand_target_map.svh"
module bit_operand_map (
	input  wire logic [7:0] bitAddr,    // bit operand byte
	output logic      [1:0] bitSpace,   // flag area or register bit
	output logic      [7:0] byteAddr,   // byte holding the bit
	output logic      [2:0] bitIndex    // bit inside that byte
);
	// --------------------------------------------------
	// decoding
	// --------------------------------------------------
	wire isFlag;                        // lower half selects flag bits
	assign isFlag   = (bitAddr < `FLAG_LIMIT);
	assign bitSpace = isFlag ? `SEL_FLAG : `SEL_REGBIT;
	// flags live in a 16-byte area, register bits in addressable registers
	assign byteAddr = isFlag ? (`REGBIT_GRP + {4'h0, bitAddr[`FLAG_BYTE_MSB:`BIT_BYTE_LSB]})
	                         : {bitAddr[`BIT_BYTE_MSB:`BIT_BYTE_LSB], 3'h0};
	assign bitIndex = bitAddr[`BIT_IDX_MSB:0];
endmodule : bit_operand_map

// ==== design/cpu_operand_target_decode.sv ====
// operand and branch-target decoder for the core
// Behaviour
// - long call/jump take full sixteen-bit target
// - page call/jump stay in next page
// - short/conditional jumps add signed byte offset
// - word immediate from bytes two and three
// - byte immediate comes from byte two, zero-extended
// - bit operand reaches flags, pins, control
`timescale 1ns/1ns
`include "operand_target_map.svh"
module cpu_operand_target_decode (
	input  wire logic        mclk,         // core clock
	input  wire logic        rst,          // synchronous reset, active high
	input  wire logic        ce,           // clock enable
	input  wire logic        decodeValid,  // instruction bytes present
	input  wire logic [2:0]  targetSel,    // operand_target_pkg::target_form_t
	input  wire logic [1:0]  immSel,       // operand_target_pkg::imm_form_t
	input  wire logic        bitSel,       // second byte is a bit operand
	input  wire logic [15:0] nextPc,       // address of following instruction
	input  wire logic [7:0]  opByte1,      // first instruction byte
	input  wire logic [7:0]  opByte2,      // second instruction byte
	input  wire logic [7:0]  opByte3,      // third instruction byte
	input  wire logic        relUsesByte3, // offset is in third byte
	output logic             targetValid,  // target address is valid
	output logic      [15:0] target,       // branch or call target
	output logic             immValid,     // immediate is valid
	output logic      [15:0] immValue,     // immediate operand
	output logic             bitValid,     // bit operand is valid
	output logic      [1:0]  bitSpace,     // flag area or register bit
	output logic      [7:0]  bitByte,      // byte holding the bit
	output logic      [2:0]  bitIndex      // bit position
);
	// --------------------------------------------------
	// target forming
	// --------------------------------------------------
	operand_target_pkg::target_form_t tform;   // decoded target form
	operand_target_pkg::imm_form_t    iform;   // decoded immediate form
	assign tform = operand_target_pkg::target_form_t'(targetSel);
	assign iform = operand_target_pkg::imm_form_t'(immSel);

	wire [15:0] fullTarget;   // full_target from bytes two and three
	wire [15:0] pageTarget;   // page_target merged into next page
	wire [7:0]  relByte;      // signed offset byte
	wire [15:0] relTarget;    // next pc plus signed offset
	assign fullTarget = {opByte2, opByte3};
	// page form keeps the top of the incremented pc, so it never leaves the page
	assign pageTarget = {nextPc[`PAGE_HI_MSB:`PAGE_HI_LSB],
	                     opByte1[`PAGE_OP_MSB:`PAGE_OP_LSB], opByte2};
	assign relByte    = relUsesByte3 ? opByte3 : opByte2;
	assign relTarget  = nextPc + {{8{relByte[7]}}, relByte};

	logic [15:0] next_target;  // selected target
	logic        next_tvalid;  // target produced this cycle
	// pick the target form; the none codes leave the valid flag low
	always_comb begin
		next_target = `PC_RESET;
		next_tvalid = 1'b0;
		case (tform)
			operand_target_pkg::TGT_FULL: begin
				next_target = fullTarget;
				next_tvalid = decodeValid;
			end
			operand_target_pkg::TGT_PAGE: begin
				next_target = pageTarget;
				next_tvalid = decodeValid;
			end
			operand_target_pkg::TGT_REL: begin
				next_target = relTarget;
				next_tvalid = decodeValid;
			end
			default: begin
				next_target = `PC_RESET;
				next_tvalid = 1'b0;
			end
		endcase
	end

	// --------------------------------------------------
	// immediate operands
	// --------------------------------------------------
	logic [15:0] next_imm;   // selected immediate
	logic        next_ival;  // immediate produced
	// pick the immediate form; byte form is zero-extended
	always_comb begin
		next_imm  = `IMM_RESET;
		next_ival = 1'b0;
		case (iform)
			operand_target_pkg::IMM_BYTE: begin
				next_imm  = {8'h00, opByte2};
				next_ival = decodeValid;
			end
			operand_target_pkg::IMM_WORD: begin
				next_imm  = {opByte2, opByte3};
				next_ival = decodeValid;
			end
			default: begin            // no immediate in this instruction
				next_imm  = `IMM_RESET;
				next_ival = 1'b0;
			end
		endcase
	end

	// --------------------------------------------------
	// bit operand
	// --------------------------------------------------
	wire [1:0] bSpace;  // decoded space
	wire [7:0] bByte;   // decoded byte
	wire [2:0] bIdx;    // decoded index
	bit_operand_map uBit (
		.bitAddr  (opByte2),
		.bitSpace (bSpace),
		.byteAddr (bByte),
		.bitIndex (bIdx)
	);

	// --------------------------------------------------
	// output registers
	// --------------------------------------------------
	// every output is registered; clock enable low freezes them all
	always_ff @(posedge mclk) begin
		if (rst) begin
			targetValid <= 1'b0;
			target      <= `PC_RESET;
			immValid    <= 1'b0;
			immValue    <= `IMM_RESET;
			bitValid    <= 1'b0;
			bitSpace    <= `SEL_FLAG;
			bitByte     <= 8'h00;
			bitIndex    <= 3'h0;
		end else if (ce) begin
			targetValid <= next_tvalid;
			target      <= next_target;
			immValid    <= next_ival;
			immValue    <= next_imm;
			bitValid    <= decodeValid & bitSel;
			bitSpace    <= bSpace;
			bitByte     <= bByte;
			bitIndex    <= bIdx;
		end
	end

	// --------------------------------------------------
	// checks
	// --------------------------------------------------
	// long forms: byte two is the high half, byte three the low half
	chk_full_target: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_FULL
		|=> target == {$past(opByte2), $past(opByte3)} && targetValid)
		else $error("full target wrong");
	// no target form selected: the target flag stays low
	chk_none_target: assert property (@(posedge mclk) disable iff (rst)
		ce && tform == operand_target_pkg::TGT_NONE
		|=> !targetValid)
		else $error("target flagged without a form");
	// nothing presented: no operand may be flagged valid
	chk_idle_valid: assert property (@(posedge mclk) disable iff (rst)
		ce && !decodeValid
		|=> !targetValid && !immValid && !bitValid)
		else $error("operand flagged while idle");

	// page forms: upper five bits follow the incremented pc
	chk_page_same: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_PAGE
		|=> target[15:11] == $past(nextPc[15:11]))
		else $error("page target left page");
	// page forms: low eleven bits come from the opcode and byte two
	chk_page_low: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_PAGE
		|=> target[10:0] == {$past(opByte1[7:5]), $past(opByte2)})
		else $error("page low bits wrong");
	// page forms: every decode yields a valid target
	chk_page_valid: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_PAGE
		|=> targetValid)
		else $error("page target not flagged valid");

	// relative forms: the distance from the next pc stays in one signed byte
	chk_rel_offset: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_REL
		|=> $signed(target - $past(nextPc)) <= 16'sh007f
		    && $signed(target - $past(nextPc)) >= -16'sh0080)
		else $error("relative target out of range");
	// relative forms: exact sum when the offset sits in byte two
	chk_rel_byte2: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_REL && !relUsesByte3
		|=> targetValid
		    && target == $past(nextPc) + {{8{$past(opByte2[7])}}, $past(opByte2)})
		else $error("relative target from byte two wrong");
	// relative forms: exact sum when the offset sits in byte three
	chk_rel_byte3: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && tform == operand_target_pkg::TGT_REL && relUsesByte3
		|=> targetValid
		    && target == $past(nextPc) + {{8{$past(opByte3[7])}}, $past(opByte3)})
		else $error("relative target from byte three wrong");

	// immediates: word form takes bytes two and three, high byte first
	chk_word_imm: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && iform == operand_target_pkg::IMM_WORD
		|=> immValid && immValue == {$past(opByte2), $past(opByte3)})
		else $error("word immediate wrong");
	// immediates: byte form is byte two, zero-extended
	chk_byte_imm: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && iform == operand_target_pkg::IMM_BYTE
		|=> immValid && immValue[15:8] == 8'h00 && immValue[7:0] == $past(opByte2))
		else $error("byte immediate wrong");
	// immediates: no form selected leaves the flag low
	chk_imm_none: assert property (@(posedge mclk) disable iff (rst)
		ce && iform == operand_target_pkg::IMM_NONE
		|=> !immValid)
		else $error("immediate flagged without a form");

	// bit operands: lower half reaches the software flag area
	chk_bit_flag: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && bitSel && !opByte2[7]
		|=> bitValid && bitSpace == `SEL_FLAG && bitIndex == $past(opByte2[2:0]))
		else $error("flag bit decode wrong");
	// bit operands: flag byte is the group base plus the flag's byte number
	chk_flag_byte: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && bitSel && !opByte2[7]
		|=> bitByte == `REGBIT_GRP + {4'h0, $past(opByte2[6:3])})
		else $error("flag bit byte wrong");
	// bit operands: upper half reaches pin, control and status registers
	chk_bit_reg: assert property (@(posedge mclk) disable iff (rst)
		ce && decodeValid && bitSel && opByte2[7]
		|=> bitSpace == `SEL_REGBIT && bitByte == {$past(opByte2[7:3]), 3'h0})
		else $error("register bit decode wrong");
	// bit operands: flag stays low without a bit request
	chk_bit_idle: assert property (@(posedge mclk) disable iff (rst)
		ce && !(decodeValid && bitSel)
		|=> !bitValid)
		else $error("bit operand flagged without request");

	// clock enable low: target, immediate, bit valid and bit byte may not move
	chk_hold_freeze: assert property (@(posedge mclk) disable iff (rst)
		!ce |=> $stable(target) && $stable(targetValid)
		    && $stable(immValue) && $stable(immValid)
		    && $stable(bitValid) && $stable(bitByte))
		else $error("state moved with clock enable low");
endmodule : cpu_operand_target_decode

// ==== testbench/testbench.sv ====
// self-checking bench for the operand and branch-target decoder
`timescale 1ns/1ns
module testbench;
	logic        mclk = 1'b0;         // core clock
	logic        rst = 1'b1;          // synchronous reset
	logic        ce = 1'b1;           // clock enable
	logic        decodeValid = 1'b0;  // bytes present
	logic [2:0]  targetSel = 3'h0;    // target form
	logic [1:0]  immSel = 2'h0;       // immediate form
	logic        bitSel = 1'b0;       // bit operand present
	logic [15:0] nextPc = 16'h0000;   // following instruction address
	logic [7:0]  opByte1 = 8'h00;     // instruction byte 1
	logic [7:0]  opByte2 = 8'h00;     // instruction byte 2
	logic [7:0]  opByte3 = 8'h00;     // instruction byte 3
	logic        relUsesByte3 = 1'b0; // offset in byte 3
	logic        targetValid, immValid, bitValid;
	logic [15:0] target, immValue;
	logic [1:0]  bitSpace;
	logic [7:0]  bitByte, bitAddr;
	logic [2:0]  bitIndex;
	int          miscompares = 0;     // mismatches seen
	int          compares = 0;        // comparisons made
	// 25 MHz clock
	always #20 mclk = ~mclk;
	cpu_operand_target_decode u_cpu_operand_target_decode (.mclk, .rst, .ce, .decodeValid,
		.targetSel, .immSel, .bitSel, .nextPc, .opByte1, .opByte2, .opByte3, .relUsesByte3,
		.targetValid, .target, .immValid, .immValue, .bitValid, .bitSpace, .bitByte, .bitIndex);
	// compare a value of up to sixteen bits
	task cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp_word
	// present one decode at a falling edge, return after the answer edge
	task go(input logic [2:0] ts, input logic [1:0] is, input logic bs, input logic [15:0] pc,
		input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3, input logic r3);
		targetSel = ts;
		immSel = is;
		bitSel = bs;
		nextPc = pc;
		opByte1 = b1;
		opByte2 = b2;
		opByte3 = b3;
		relUsesByte3 = r3;
		decodeValid = 1'b1;
		@(negedge mclk);
	endtask : go
	// jump forms back to back: full, page, relative
	task test_targets;
		go(3'h1, 2'h0, 1'b0, 16'h1234, 8'h02, 8'hff, 8'hfe, 1'b0);
		cmp_word(target, 16'hfffe, "full high");
		cmp_word({15'h0, targetValid}, 16'h0001, "full valid");
		go(3'h1, 2'h0, 1'b0, 16'hffff, 8'h02, 8'h00, 8'h00, 1'b0);
		cmp_word(target, 16'h0000, "full low");
		go(3'h2, 2'h0, 1'b0, 16'hf800, 8'he1, 8'h5a, 8'h00, 1'b0);
		cmp_word(target, 16'hff5a, "page top");
		go(3'h2, 2'h0, 1'b0, 16'h0800, 8'h11, 8'h00, 8'hff, 1'b0);
		cmp_word(target, 16'h0800, "page base");
		go(3'h3, 2'h0, 1'b0, 16'h1000, 8'h80, 8'h7f, 8'h00, 1'b0);
		cmp_word(target, 16'h107f, "rel max");
		go(3'h3, 2'h0, 1'b0, 16'h0000, 8'h80, 8'h80, 8'h00, 1'b0);
		cmp_word(target, 16'hff80, "rel min wrap");
		go(3'h3, 2'h0, 1'b1, 16'h1000, 8'h20, 8'h7f, 8'hff, 1'b1);
		cmp_word(target, 16'h0fff, "rel byte3");
		$display("test targets done");
	endtask : test_targets
	// immediates and the none codes
	task test_imm;
		go(3'h0, 2'h2, 1'b0, 16'h0100, 8'h90, 8'hab, 8'hcd, 1'b0);
		cmp_word(immValue, 16'habcd, "word imm");
		cmp_word({14'h0, targetValid, immValid}, 16'h0001, "word valids");
		go(3'h0, 2'h1, 1'b0, 16'h0100, 8'h74, 8'h5c, 8'hee, 1'b0);
		cmp_word(immValue, 16'h005c, "byte imm");
		go(3'h0, 2'h0, 1'b0, 16'h0100, 8'h00, 8'h00, 8'h00, 1'b0);
		cmp_word({15'h0, immValid}, 16'h0000, "none imm");
		$display("test imm done");
	endtask : test_imm
	// bit operand at both ends of both spaces
	task test_bits;
		for (int i = 0; i < 4; i++) begin
			bitAddr = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : (i == 2) ? 8'h80 : 8'hff;
			go(3'h0, 2'h0, 1'b1, 16'h0200, 8'hd2, bitAddr, 8'h00, 1'b0);
			cmp_word({13'h0, bitValid, bitSpace}, {13'h0, 1'b1, 1'b0, bitAddr[7]}, "bit space");
			cmp_word({8'h0, bitByte}, bitAddr[7] ? {8'h0, bitAddr[7:3], 3'h0}
				: 16'h0008 + bitAddr[6:3], "bit byte");
			cmp_word({13'h0, bitIndex}, {13'h0, bitAddr[2:0]}, "bit index");
		end
		$display("test bits done");
	endtask : test_bits
	// reset in mid-run clears every flag, then decoding resumes; idle flags nothing
	task test_reset;
		go(3'h1, 2'h2, 1'b1, 16'h0000, 8'h02, 8'hab, 8'hcd, 1'b0);
		cmp_word({13'h0, targetValid, immValid, bitValid}, 16'h0007, "busy valids");
		rst = 1'b1;
		@(negedge mclk);
		cmp_word({13'h0, targetValid, immValid, bitValid}, 16'h0000, "reset valids mid");
		cmp_word(target, 16'h0000, "reset target mid");
		rst = 1'b0;
		@(negedge mclk);
		cmp_word(target, 16'habcd, "target after reset");
		cmp_word(immValue, 16'habcd, "imm after reset");
		decodeValid = 1'b0;
		@(negedge mclk);
		cmp_word({13'h0, targetValid, immValid, bitValid}, 16'h0000, "idle valids");
		$display("test reset done");
	endtask : test_reset
	// clock enable low holds the last answer
	task test_freeze;
		go(3'h1, 2'h0, 1'b0, 16'h0000, 8'h02, 8'h12, 8'h34, 1'b0);
		ce = 1'b0;
		go(3'h1, 2'h0, 1'b0, 16'h0000, 8'h02, 8'h56, 8'h78, 1'b0);
		cmp_word(target, 16'h1234, "frozen target");
		ce = 1'b1;
		@(negedge mclk);
		cmp_word(target, 16'h5678, "resumed target");
		$display("test freeze done");
	endtask : test_freeze
	// print counts and the verdict, then stop
	task give_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		cmp_word({13'h0, targetValid, immValid, bitValid}, 16'h0000, "reset valids");
		test_targets;
		test_imm;
		test_bits;
		test_reset;
		test_freeze;
		give_verdict;
	end
endmodule : testbench
